// file: rtl/dfm_cfg.svh
// Constants for the double-precision multiply-accumulate datapath
`ifndef DFM_CFG_SVH
`define DFM_CFG_SVH

// Primary opcodes
`define DFM_OP_MUL_ACC 8'hD9
`define DFM_OP_MUL_SUM 8'hDB
`define DFM_OP_MULTIPLY 8'hF5
`define DFM_OP_SUBTRACT 8'hF3

// Operation function field bits
`define DFM_FN_NEG_B 0
`define DFM_FN_SUB_C 1
`define DFM_FN_ZERO_C 2
`define DFM_FN_ONE_B 3
// Field positions inside the destination byte of multiply-accumulate
`define DFM_FN_MSB 7
`define DFM_FN_LSB 4
`define DFM_ACN_MSB 1
`define DFM_ACN_LSB 0

// Rounding mode codes
`define DFM_RM_NEAREST 2'h0
`define DFM_RM_DOWN 2'h1
`define DFM_RM_UP 2'h2
`define DFM_RM_ZERO 2'h3

// Double-precision encodings
`define DFM_SIGN_BIT 63
`define DFM_EXP_ALL1 11'h7FF
`define DFM_EXP_BIAS 1023
`define DFM_EXP_INF 2047
`define DFM_NORM_OFFSET 106
`define DFM_SUM_W 110
`define DFM_ONE 64'h3FF0_0000_0000_0000
`define DFM_POS_ZERO 64'h0000_0000_0000_0000
`define DFM_NEG_ZERO 64'h8000_0000_0000_0000
`define DFM_QNAN 64'h7FF8_0000_0000_0000
`define DFM_MAX_FIN 63'h7FEF_FFFF_FFFF_FFFF
`define DFM_INF 63'h7FF0_0000_0000_0000

`endif

// file: rtl/dfm_fma_unit.sv
// Combinational double-precision fused multiply-add with rounding
`timescale 1ns/100ps
`include "dfm_cfg.svh"

module dfm_fma_unit (
  input wire logic [63:0] a_i,
  input wire logic [63:0] b_i,
  input wire logic [63:0] c_i,
  input wire logic [1:0] rm_i,
  input wire logic ftz_i,
  output logic [63:0] res_o,
  output dfm_pkg::dfm_flags_s flags_o
);

  logic sa, sb, sc, sp, eff_sub, sgn, nan_in, pinf, cinf, pzero, czero, stk, grd, inc, away;
  logic [10:0] ea, eb, ec;
  logic [52:0] ma, mb, mc, mr;
  logic [53:0] mrnd;
  logic [105:0] pm;
  logic [109:0] vp, vc, sum, norm;
  int xp, xc, xbig, xr, d, k;

  always_comb begin
    sa = a_i[`DFM_SIGN_BIT];
    sb = b_i[`DFM_SIGN_BIT];
    sc = c_i[`DFM_SIGN_BIT];
    ea = a_i[62:52];
    eb = b_i[62:52];
    ec = c_i[62:52];
    // Tiny inputs read as zero: gradual underflow is not supported
    ma = (ea == 11'h000) ? 53'h0 : {1'b1, a_i[51:0]};
    mb = (eb == 11'h000) ? 53'h0 : {1'b1, b_i[51:0]};
    mc = (ec == 11'h000) ? 53'h0 : {1'b1, c_i[51:0]};
    sp = sa ^ sb;
    eff_sub = sp ^ sc;
    nan_in = ((ea == `DFM_EXP_ALL1) && (a_i[51:0] != 52'h0)) || ((eb == `DFM_EXP_ALL1) && (b_i[51:0] != 52'h0))
             || ((ec == `DFM_EXP_ALL1) && (c_i[51:0] != 52'h0));
    pinf = (ea == `DFM_EXP_ALL1) || (eb == `DFM_EXP_ALL1);
    cinf = (ec == `DFM_EXP_ALL1);
    pzero = (ma == 53'h0) || (mb == 53'h0);
    czero = (mc == 53'h0);
    pm = ma * mb;
    vp = pzero ? '0 : {2'h0, pm, 2'h0};
    // Addend unit bit sits at the product's unit bit position
    vc = czero ? '0 : {3'h0, mc, 52'h0, 2'h0};
    xp = int'(ea) + int'(eb) - `DFM_EXP_BIAS;
    xc = int'(ec);
    if (pzero) xp = xc;
    if (czero) xc = xp;
    xbig = (xp > xc) ? xp : xc;
    // Align the smaller operand, keeping lost bits as sticky
    stk = 1'b0;
    d = (xp > xc) ? xp - xc : xc - xp;
    if (d >= `DFM_SUM_W) begin
      stk = (xp > xc) ? (vc != '0) : (vp != '0);
      if (xp > xc) vc = '0;
      else vp = '0;
    end else if (d > 0) begin
      if (xp > xc) begin
        stk = ((vc << (`DFM_SUM_W - d)) != '0);
        vc = vc >> d;
      end else begin
        stk = ((vp << (`DFM_SUM_W - d)) != '0);
        vp = vp >> d;
      end
    end
    if (!eff_sub) begin
      sum = vp + vc;
      sgn = sp;
    end else if (vp >= vc) begin
      sum = vp - vc;
      sgn = sp;
    end else begin
      sum = vc - vp;
      sgn = sc;
    end
    k = 0;
    for (int i = 0; i < `DFM_SUM_W; i++) begin
      if (sum[i]) k = i;
    end
    norm = sum << (`DFM_SUM_W - 1 - k);
    mr = norm[109:57];
    grd = norm[56];
    stk = stk | (norm[55:0] != 56'h0);
    away = (rm_i == `DFM_RM_DOWN) ? sgn : ~sgn;
    case (rm_i)
      `DFM_RM_NEAREST: inc = grd & (stk | mr[0]);
      `DFM_RM_ZERO: inc = 1'b0;
      default: inc = (grd | stk) & away;
    endcase
    mrnd = {1'b0, mr} + {53'h0, inc};
    xr = xbig + k - `DFM_NORM_OFFSET;
    if (mrnd[53]) begin
      xr = xr + 1;
      mrnd = mrnd >> 1;
    end
    flags_o = '0;
    flags_o.inexact = grd | stk;
    res_o = {sgn, 11'(xr), mrnd[51:0]};
    if (nan_in || (pinf && (ma == 53'h0 || mb == 53'h0)) || (pinf && cinf && eff_sub)) begin
      res_o = `DFM_QNAN;
      flags_o = '0;
      flags_o.invalid = 1'b1;
    end else if (pinf || cinf) begin
      res_o = {pinf ? sp : sc, `DFM_INF};
      flags_o = '0;
    end else if (sum == '0 && !stk) begin
      // Exact zero: equal signs survive, otherwise the mode picks
      if (pzero && czero && !eff_sub) res_o = {sp, 63'h0};
      else res_o = {(rm_i == `DFM_RM_DOWN), 63'h0};
      flags_o = '0;
    end else if (xr >= `DFM_EXP_INF) begin
      res_o = {sgn, (rm_i == `DFM_RM_ZERO || (rm_i != `DFM_RM_NEAREST && !away)) ? `DFM_MAX_FIN : `DFM_INF};
      flags_o.overflow = 1'b1;
      flags_o.inexact = 1'b1;
    end else if (xr <= 0) begin
      // Fast float flushes with underflow only; otherwise the loss is also reported as inexact
      res_o = {sgn, 63'h0};
      flags_o.underflow = 1'b1;
      flags_o.inexact = ~ftz_i;
    end
  end

endmodule

// file: rtl/dfm_fp_datapath.sv
// Double-precision multiply-accumulate, multiply-sum, multiply and subtract datapath
`timescale 1ns/100ps
`include "dfm_cfg.svh"

module dfm_fp_datapath (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic issue_valid_i,
  output logic issue_ready_o,
  input wire dfm_pkg::dfm_instr_s issue_instr_i,
  output logic [31:0] rf_rd_addr_o,
  input wire logic [127:0] rf_rd_data_i,
  output logic rf_wr_en_o,
  output logic [7:0] rf_wr_addr_o,
  output logic [63:0] rf_wr_data_o,
  input wire logic [1:0] rounding_mode_field_i,
  input wire logic accumulator_format_field_i,
  input wire logic fast_float_sel_i,
  input wire dfm_pkg::dfm_flags_s trap_enable_i,
  input wire dfm_pkg::dfm_flags_s sticky_clr_i,
  output dfm_pkg::dfm_flags_s sticky_o,
  output logic fp_trap_o,
  output dfm_pkg::dfm_flags_s trap_cause_o,
  output logic done_o,
  input wire logic [1:0] acc_rd_sel_i,
  output logic [63:0] acc_rd_data_o
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] twin_of(input logic [7:0] r);
    twin_of = {r[7:1], ~r[0]};
  endfunction

  function automatic logic is_known(input logic [7:0] op);
    is_known = (op == `DFM_OP_MUL_ACC) || (op == `DFM_OP_MUL_SUM) || (op == `DFM_OP_MULTIPLY)
               || (op == `DFM_OP_SUBTRACT);
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  dfm_pkg::dfm_state_e state_reg;
  logic [7:0] op_reg;
  logic [7:0] destination_reg;
  logic [63:0] opa_reg;
  logic [63:0] opb_reg;
  logic [63:0] opc_reg;
  logic [63:0] acc_reg [4];
  logic [63:0] fma_a_next;
  logic [63:0] fma_b_next;
  logic [63:0] fma_c_next;
  logic [63:0] fma_res;
  logic fma_ftz;
  logic accum_form;
  logic issue_take;
  logic [3:0] operation_function_field;
  logic [1:0] accumulator_select;
  dfm_pkg::dfm_flags_s fma_flags;
  dfm_pkg::dfm_flags_s sticky_set;
  dfm_pkg::dfm_flags_s trap_hit;

  assign issue_ready_o = (state_reg == dfm_pkg::DFM_IDLE);
  assign issue_take = issue_valid_i && issue_ready_o && is_known(issue_instr_i.opcode);
  // Accumulator format is trusted to select double precision here
  assign accum_form = (op_reg == `DFM_OP_MUL_ACC) || (op_reg == `DFM_OP_MUL_SUM);
  assign operation_function_field = destination_reg[`DFM_FN_MSB:`DFM_FN_LSB];
  assign accumulator_select = destination_reg[`DFM_ACN_MSB:`DFM_ACN_LSB];

  // ----------------------------------------
  // Operand fetch
  // ----------------------------------------
  // Named register holds the upper word, its twin the lower word
  assign rf_rd_addr_o = {issue_instr_i.first_source, twin_of(issue_instr_i.first_source),
                         issue_instr_i.second_source, twin_of(issue_instr_i.second_source)};

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= dfm_pkg::DFM_IDLE;
    end else begin
      case (state_reg)
        dfm_pkg::DFM_IDLE: begin
          if (issue_take) state_reg <= dfm_pkg::DFM_EXEC;
        end
        dfm_pkg::DFM_EXEC: state_reg <= dfm_pkg::DFM_IDLE;
        default: state_reg <= dfm_pkg::DFM_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      op_reg <= 8'h00;
      destination_reg <= 8'h00;
      opa_reg <= `DFM_POS_ZERO;
      opb_reg <= `DFM_POS_ZERO;
      opc_reg <= `DFM_POS_ZERO;
    end else if (issue_take) begin
      op_reg <= issue_instr_i.opcode;
      destination_reg <= issue_instr_i.destination;
      opa_reg <= rf_rd_data_i[127:64];
      opb_reg <= rf_rd_data_i[63:0];
      // Sum form always reads accumulator zero
      if (issue_instr_i.opcode == `DFM_OP_MUL_SUM) opc_reg <= acc_reg[0];
      else opc_reg <= acc_reg[issue_instr_i.destination[`DFM_ACN_MSB:`DFM_ACN_LSB]];
    end
  end

  // ----------------------------------------
  // Operand shaping
  // ----------------------------------------
  always_comb begin
    fma_a_next = opa_reg;
    fma_b_next = opb_reg;
    fma_c_next = `DFM_NEG_ZERO;
    fma_ftz = fast_float_sel_i;
    case (op_reg)
      `DFM_OP_MUL_ACC: begin
        fma_ftz = 1'b1;
        fma_b_next = operation_function_field[`DFM_FN_ONE_B] ? `DFM_ONE : opb_reg;
        fma_b_next[`DFM_SIGN_BIT] = fma_b_next[`DFM_SIGN_BIT] ^ operation_function_field[`DFM_FN_NEG_B];
        fma_c_next = operation_function_field[`DFM_FN_ZERO_C] ? `DFM_POS_ZERO : opc_reg;
        fma_c_next[`DFM_SIGN_BIT] = fma_c_next[`DFM_SIGN_BIT] ^ operation_function_field[`DFM_FN_SUB_C];
      end
      `DFM_OP_MUL_SUM: begin
        fma_ftz = 1'b1;
        fma_b_next = opc_reg;
        fma_c_next = opb_reg;
      end
      `DFM_OP_SUBTRACT: begin
        fma_b_next = `DFM_ONE;
        fma_c_next = {~opb_reg[`DFM_SIGN_BIT], opb_reg[62:0]};
      end
      // Negative zero addend leaves the product's zero sign intact, except a +0 product turns -0 in round-down mode
      default: fma_c_next = `DFM_NEG_ZERO;
    endcase
  end

  dfm_fma_unit u_fma (
    .a_i(fma_a_next),
    .b_i(fma_b_next),
    .c_i(fma_c_next),
    .rm_i(rounding_mode_field_i),
    .ftz_i(fma_ftz),
    .res_o(fma_res),
    .flags_o(fma_flags)
  );

  // ----------------------------------------
  // Result write-back
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < 4; i++) acc_reg[i] <= `DFM_POS_ZERO;
    end else if (state_reg == dfm_pkg::DFM_EXEC && op_reg == `DFM_OP_MUL_ACC) begin
      acc_reg[accumulator_select] <= fma_res;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rf_wr_en_o <= 1'b0;
      rf_wr_addr_o <= 8'h00;
      rf_wr_data_o <= `DFM_POS_ZERO;
      done_o <= 1'b0;
    end else begin
      rf_wr_en_o <= (state_reg == dfm_pkg::DFM_EXEC) && (op_reg != `DFM_OP_MUL_ACC) && !fp_trap_next();
      done_o <= (state_reg == dfm_pkg::DFM_EXEC);
      if (state_reg == dfm_pkg::DFM_EXEC) begin
        rf_wr_addr_o <= destination_reg;
        rf_wr_data_o <= fma_res;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) acc_rd_data_o <= `DFM_POS_ZERO;
    else acc_rd_data_o <= acc_reg[acn_rd_sel()];
  end

  function automatic logic [1:0] acn_rd_sel();
    acn_rd_sel = acc_rd_sel_i;
  endfunction

  // ----------------------------------------
  // Exceptions and sticky status
  // ----------------------------------------
  function automatic logic fp_trap_next();
    fp_trap_next = (state_reg == dfm_pkg::DFM_EXEC) && !accum_form && ((fma_flags & trap_enable_i) != '0);
  endfunction

  always_comb begin
    trap_hit = '0;
    sticky_set = '0;
    if (state_reg == dfm_pkg::DFM_EXEC) begin
      if (accum_form) begin
        sticky_set = fma_flags;
        sticky_set.inexact = 1'b0;
      end else begin
        trap_hit = fma_flags & trap_enable_i;
        sticky_set = (trap_hit != '0) ? '0 : fma_flags;
      end
    end
  end

  // Set beats clear so an exception in the clearing cycle is kept
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) sticky_o <= '0;
    else sticky_o <= (sticky_o & ~sticky_clr_i) | sticky_set;
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fp_trap_o <= 1'b0;
      trap_cause_o <= '0;
    end else begin
      fp_trap_o <= fp_trap_next();
      if (fp_trap_next()) trap_cause_o <= trap_hit;
    end
  end

endmodule

// file: rtl/dfm_pkg.sv
// Types for the double-precision multiply-accumulate datapath
package dfm_pkg;

  typedef struct packed {
    logic invalid;
    logic overflow;
    logic underflow;
    logic inexact;
  } dfm_flags_s;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] destination;
    logic [7:0] first_source;
    logic [7:0] second_source;
  } dfm_instr_s;

  typedef enum logic [0:0] {
    DFM_IDLE,
    DFM_EXEC
  } dfm_state_e;

endpackage

// file: testbench/dfm_fp_datapath_bench.sv
// Self-checking bench for the double-precision datapath
`timescale 1ns/100ps
`include "dfm_cfg.svh"
module dfm_fp_datapath_bench;
  logic ref_clk_i, nrst_i, issue_valid_i, issue_ready_o, rf_wr_en_o, fp_trap_o, done_o;
  logic accumulator_format_field_i, fast_float_sel_i, wr_seen, trap_seen;
  dfm_pkg::dfm_instr_s issue_instr_i;
  logic [31:0] rf_rd_addr_o;
  logic [127:0] rf_rd_data_i;
  logic [7:0] rf_wr_addr_o;
  logic [63:0] rf_wr_data_o, acc_rd_data_o;
  logic [1:0] rounding_mode_field_i, acc_rd_sel_i;
  dfm_pkg::dfm_flags_s trap_enable_i, sticky_clr_i, sticky_o, trap_cause_o;
  int mismatches, checked;
  logic [3:0] fn [10] = '{4'hC, 4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h9, 4'hE, 4'h7, 4'hB};
  logic [15:0] ex [10] = '{16'h4000, 16'h4020, 16'h4000, 16'h4010, 16'hC024, 16'h4018, 16'h4010,
    16'h4000, 16'hC018, 16'h4010};
  dfm_fp_datapath uut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .issue_valid_i(issue_valid_i),
    .issue_ready_o(issue_ready_o), .issue_instr_i(issue_instr_i), .rf_rd_addr_o(rf_rd_addr_o),
    .rf_rd_data_i(rf_rd_data_i), .rf_wr_en_o(rf_wr_en_o), .rf_wr_addr_o(rf_wr_addr_o),
    .rf_wr_data_o(rf_wr_data_o), .rounding_mode_field_i(rounding_mode_field_i),
    .accumulator_format_field_i(accumulator_format_field_i), .fast_float_sel_i(fast_float_sel_i),
    .trap_enable_i(trap_enable_i), .sticky_clr_i(sticky_clr_i), .sticky_o(sticky_o),
    .fp_trap_o(fp_trap_o), .trap_cause_o(trap_cause_o), .done_o(done_o), .acc_rd_sel_i(acc_rd_sel_i),
    .acc_rd_data_o(acc_rd_data_o));
  dfm_rf_model rf (.ref_clk_i(ref_clk_i), .rd_addr_i(rf_rd_addr_o), .rd_data_o(rf_rd_data_i),
    .wr_en_i(rf_wr_en_o), .wr_addr_i(rf_wr_addr_o), .wr_data_i(rf_wr_data_o));
  // ------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------
  function automatic logic [63:0] dv(input logic [15:0] top);
    return {top, 48'h0};
  endfunction
  task automatic put(input logic [7:0] r, input logic [63:0] v);
    rf.mem[r] = v[63:32];
    rf.mem[r ^ 8'h01] = v[31:0];
  endtask
  function automatic logic [63:0] get(input logic [7:0] r);
    return {rf.mem[r], rf.mem[r ^ 8'h01]};
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Holds valid for the take edge only, then waits for done
  task automatic run(input logic [7:0] op, input logic [7:0] d, input logic [7:0] a, input logic [7:0] b);
    int n;
    @(negedge ref_clk_i);
    issue_instr_i = {op, d, a, b};
    issue_valid_i = 1'b1;
    @(negedge ref_clk_i);
    issue_valid_i = 1'b0;
    n = 0;
    while (done_o !== 1'b1 && n < 8) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (done_o !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED t=%0t no done", $time);
      tally_and_finish();
    end else begin
      wr_seen = rf_wr_en_o;
      trap_seen = fp_trap_o;
      // Register file takes the write at the next edge
      @(negedge ref_clk_i);
    end
  endtask
  task automatic acc_chk(input logic [1:0] sel, input logic [63:0] exp);
    acc_rd_sel_i = sel;
    @(negedge ref_clk_i);
    check(acc_rd_data_o, exp);
  endtask
  task automatic clr;
    sticky_clr_i = 4'hF;
    @(negedge ref_clk_i);
    sticky_clr_i = 4'h0;
  endtask
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    nrst_i = 1'b0;
    issue_valid_i = 1'b0;
    issue_instr_i = '0;
    rounding_mode_field_i = `DFM_RM_NEAREST;
    accumulator_format_field_i = 1'b1;
    fast_float_sel_i = 1'b0;
    trap_enable_i = 4'h0;
    sticky_clr_i = 4'h0;
    acc_rd_sel_i = 2'h0;
    put(8'h02, dv(16'h4000));
    put(8'h04, dv(16'h4008));
    put(8'h06, dv(16'h4014));
    put(8'h08, 64'h3FB999999999999A);
    put(8'h0A, 64'h7FEFFFFFFFFFFFFF);
    put(8'h0C, 64'h0);
    put(8'h0E, 64'h0010000000000000);
    put(8'h10, 64'h3C30000000000000);
    repeat (16) @(negedge ref_clk_i);
    nrst_i = 1'b1;
    run(`DFM_OP_MULTIPLY, 8'h14, 8'h02, 8'h04);
    check(get(8'h14), dv(16'h4018));
    run(`DFM_OP_SUBTRACT, 8'h16, 8'h06, 8'h04);
    check(get(8'h16), dv(16'h4000));
    $display("test multiply and subtract done");
    // Fast float on: accumulate forms must ignore it
    fast_float_sel_i = 1'b1;
    for (int i = 0; i < 10; i++) begin
      run(`DFM_OP_MUL_ACC, {fn[i], 4'h3}, 8'h02, 8'h04);
      acc_chk(2'h3, dv(ex[i]));
    end
    acc_chk(2'h1, 64'h0);
    run(`DFM_OP_MUL_ACC, 8'hC0, 8'h04, 8'h04);
    acc_chk(2'h3, dv(16'h4010));
    acc_chk(2'h0, dv(16'h4008));
    $display("test accumulate functions done");
    run(`DFM_OP_MUL_SUM, 8'h18, 8'h02, 8'h06);
    check(get(8'h18), dv(16'h4026));
    check({60'h0, sticky_o}, 64'h0);
    $display("test multiply-sum done");
    fast_float_sel_i = 1'b0;
    run(`DFM_OP_MULTIPLY, 8'h1A, 8'h08, 8'h08);
    check({63'h0, sticky_o.inexact}, 64'h1);
    clr();
    run(`DFM_OP_MUL_ACC, 8'h41, 8'h08, 8'h08);
    run(`DFM_OP_MUL_SUM, 8'h1C, 8'h08, 8'h08);
    check({60'h0, sticky_o}, 64'h0);
    $display("test inexact done");
    run(`DFM_OP_MULTIPLY, 8'h22, 8'h0E, 8'h08);
    check({60'h0, sticky_o}, 64'h3);
    check(get(8'h22), 64'h0);
    clr();
    fast_float_sel_i = 1'b1;
    run(`DFM_OP_MULTIPLY, 8'h22, 8'h0E, 8'h08);
    check({60'h0, sticky_o}, 64'h2);
    fast_float_sel_i = 1'b0;
    rounding_mode_field_i = `DFM_RM_DOWN;
    run(`DFM_OP_SUBTRACT, 8'h24, 8'h02, 8'h10);
    check(get(8'h24), 64'h3FFFFFFFFFFFFFFF);
    rounding_mode_field_i = `DFM_RM_UP;
    run(`DFM_OP_SUBTRACT, 8'h24, 8'h02, 8'h10);
    check(get(8'h24), 64'h4000000000000000);
    rounding_mode_field_i = `DFM_RM_ZERO;
    run(`DFM_OP_SUBTRACT, 8'h24, 8'h02, 8'h10);
    check(get(8'h24), 64'h3FFFFFFFFFFFFFFF);
    rounding_mode_field_i = `DFM_RM_NEAREST;
    clr();
    $display("test underflow and rounding done");
    trap_enable_i = 4'hF;
    run(`DFM_OP_MUL_ACC, 8'h42, 8'h0A, 8'h02);
    check({62'h0, trap_seen, wr_seen}, 64'h0);
    check({60'h0, sticky_o}, 64'h4);
    acc_chk(2'h2, 64'h7FF0000000000000);
    clr();
    run(`DFM_OP_MUL_ACC, 8'hC0, 8'h0A, 8'h02);
    clr();
    run(`DFM_OP_MUL_SUM, 8'h1E, 8'h02, 8'h0C);
    check({62'h0, trap_seen, wr_seen}, 64'h1);
    check({60'h0, sticky_o}, 64'h4);
    check(get(8'h1E), 64'h7FF0000000000000);
    clr();
    run(`DFM_OP_MULTIPLY, 8'h20, 8'h0A, 8'h02);
    check({58'h0, sticky_o, trap_seen, wr_seen}, 64'h2);
    check({60'h0, trap_cause_o}, 64'h5);
    $display("test overflow and trap done");
    tally_and_finish();
  end
endmodule
bind dfm_fp_datapath dfm_fp_datapath_chk chk (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
  .issue_valid_i(issue_valid_i), .issue_ready_o(issue_ready_o), .issue_instr_i(issue_instr_i),
  .rf_rd_addr_o(rf_rd_addr_o), .rf_wr_en_o(rf_wr_en_o), .rf_wr_addr_o(rf_wr_addr_o),
  .sticky_o(sticky_o), .fp_trap_o(fp_trap_o), .done_o(done_o));

// file: testbench/dfm_fp_datapath_chk.sv
// Port-level assertions for the double-precision datapath
`timescale 1ns/100ps
`include "dfm_cfg.svh"
module dfm_fp_datapath_chk (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic issue_valid_i,
  input wire logic issue_ready_o,
  input wire dfm_pkg::dfm_instr_s issue_instr_i,
  input wire logic [31:0] rf_rd_addr_o,
  input wire logic rf_wr_en_o,
  input wire logic [7:0] rf_wr_addr_o,
  input wire dfm_pkg::dfm_flags_s sticky_o,
  input wire logic fp_trap_o,
  input wire logic done_o
);
  logic take;
  logic [7:0] op;
  logic [7:0] ra;
  logic [7:0] rb;
  assign op = issue_instr_i.opcode;
  assign ra = issue_instr_i.first_source;
  assign rb = issue_instr_i.second_source;
  assign take = issue_valid_i && issue_ready_o &&
    (op inside {`DFM_OP_MUL_ACC, `DFM_OP_MUL_SUM, `DFM_OP_MULTIPLY, `DFM_OP_SUBTRACT});
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  busy_one_cycle_a: assert property (take |=> !issue_ready_o ##1 issue_ready_o)
    else $error("ready not low for exactly one cycle after a take");
  done_pulse_a: assert property (take |-> ##2 done_o ##1 !done_o)
    else $error("done pulse missing or too long");
  acc_no_write_a: assert property (take && op == `DFM_OP_MUL_ACC |-> ##2 !rf_wr_en_o && !fp_trap_o)
    else $error("accumulate form wrote a register or trapped");
  sum_writes_a: assert property (take && op == `DFM_OP_MUL_SUM |-> ##2 rf_wr_en_o && !fp_trap_o)
    else $error("multiply-sum did not write or trapped");
  mul_sub_a: assert property (take && op[7:4] == 4'hF |-> ##2 rf_wr_en_o != fp_trap_o)
    else $error("multiply or subtract gave neither write nor trap");
  wr_destination_a: assert property (rf_wr_en_o |-> rf_wr_addr_o == $past(issue_instr_i.destination, 2))
    else $error("write address is not the destination byte");
  inexact_kept_a: assert property (take && op inside {`DFM_OP_MUL_ACC, `DFM_OP_MUL_SUM}
    && !sticky_o.inexact |-> ##2 !sticky_o.inexact)
    else $error("accumulate form set inexact sticky");
  pair_read_a: assert property (issue_valid_i |-> rf_rd_addr_o == {ra, ra ^ 8'h01, rb, rb ^ 8'h01})
    else $error("operand pair read addresses wrong");
  cover property (take && op == `DFM_OP_MUL_ACC);
  cover property (take && op == `DFM_OP_MUL_SUM);
  cover property (fp_trap_o);
endmodule

// file: testbench/dfm_rf_model.sv
// Register file model answering the datapath's operand reads
`timescale 1ns/100ps
module dfm_rf_model (
  input wire logic ref_clk_i,
  input wire logic [31:0] rd_addr_i,
  output logic [127:0] rd_data_o,
  input wire logic wr_en_i,
  input wire logic [7:0] wr_addr_i,
  input wire logic [63:0] wr_data_i
);
  logic [31:0] mem [256];
  // Same-cycle read: operands are sampled at the take edge
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      rd_data_o[i*32 +: 32] = mem[rd_addr_i[i*8 +: 8]];
    end
  end
  // Named register takes the high word, its twin the low word
  always @(posedge ref_clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i[63:32];
      mem[wr_addr_i ^ 8'h01] <= wr_data_i[31:0];
    end
  end
endmodule
